// *** core/awdf_pkg.sv ***
package awdf_pkg;
  // data path and buffer geometry
  localparam int DATA_W = 32;
  localparam int DEPTH  = 16;
  localparam int AW     = 4;
  localparam int CNT_W  = AW + 2;
  localparam int TH_W   = AW;
  localparam logic [CNT_W-1:0] DEPTH_CNT = 6'h10;

  // register bus
  localparam int CFG_AW = 8;
  localparam logic [CFG_AW-1:0] CTRL_OFS     = 8'h00;
  localparam logic [CFG_AW-1:0] FULL_TH_OFS  = 8'h04;
  localparam logic [CFG_AW-1:0] EMPTY_TH_OFS = 8'h08;
  localparam logic [CFG_AW-1:0] STATUS_OFS   = 8'h0c;
  localparam logic [CFG_AW-1:0] COUNT_OFS    = 8'h10;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // control register fields
  localparam int CTRL_ECC_EN_BIT = 0;
  localparam int CTRL_INJ_S_BIT  = 1;
  localparam int CTRL_INJ_D_BIT  = 2;
  localparam int CTRL_HOLD_BIT   = 3;
  localparam int CTRL_W          = 4;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;

  // threshold reset values
  localparam logic [TH_W-1:0] FULL_TH_RST  = 4'hc;
  localparam logic [TH_W-1:0] EMPTY_TH_RST = 4'h2;

  // status register fields
  localparam int ST_SBIT   = 0;
  localparam int ST_DBIT   = 1;
  localparam int ST_OVF    = 2;
  localparam int ST_UNF    = 3;
  localparam int ST_PFULL  = 4;
  localparam int ST_PEMPTY = 5;
  localparam int ST_FULL   = 6;
  localparam int ST_EMPTY  = 7;

  // code word positions flipped by error injection
  localparam int INJ_POS_A = 3;
  localparam int INJ_POS_B = 5;

  // number of hamming check bits for k payload bits
  function automatic int par_bits(input int k);
    int p;
    p = 1;
    while ((1 << p) < (k + p + 1)) p++;
    return p;
  endfunction
endpackage

// *** core/awdf_top.sv ***
// Function
// - strobe bit n qualifies data byte n
// - output valid high exactly while word presented
// - empty threshold changes only during hold reset
// - single-error injection flips one stored bit
// - double-error injection flips two stored bits
// - flag corrected single-bit error on readout
// - flag detected double-bit error on readout
// - overflow held at zero, never raised after a rejected write
// - overflow may stay zero under handshake
// - write count never under-reports, updates on the write edge
// - underflow held at zero, never raised after a rejected read
// - underflow may stay zero under handshake
// - read count never over-reports, updates on the read edge
// - common clock data count of stored words
// - almost-full high while count at/above threshold
// - almost-empty high while count at/below threshold
// - data width 8 to 512, strobes width/8
`timescale 1ns/1ps
module awdf_top #(
  parameter int DATA_W = awdf_pkg::DATA_W
) (
  // clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_i,
  // upstream write data channel
  input  wire logic [DATA_W-1:0]            s_axi_wdata_i,
  input  wire logic [DATA_W/8-1:0]          s_axi_wstrb_i,
  input  wire logic                         s_axi_wvalid_i,
  output logic                              s_axi_wready_o,
  // downstream write data channel
  output logic [DATA_W-1:0]                 m_axi_wdata_o,
  output logic [DATA_W/8-1:0]               m_axi_wstrb_o,
  output logic                              m_axi_wvalid_o,
  input  wire logic                         m_axi_wready_i,
  // sideband status
  output logic                              sbiterr_o,
  output logic                              dbiterr_o,
  output logic                              overflow_o,
  output logic                              underflow_o,
  output logic                              prog_full_o,
  output logic                              prog_empty_o,
  output logic [awdf_pkg::CNT_W-1:0]        wr_data_count_o,
  output logic [awdf_pkg::CNT_W-1:0]        rd_data_count_o,
  output logic [awdf_pkg::CNT_W-1:0]        data_count_o,
  // configuration bus, axi4-lite
  input  wire logic [awdf_pkg::CFG_AW-1:0]  cfg_awaddr_i,
  input  wire logic                         cfg_awvalid_i,
  output logic                              cfg_awready_o,
  input  wire logic [31:0]                  cfg_wdata_i,
  input  wire logic [3:0]                   cfg_wstrb_i,
  input  wire logic                         cfg_wvalid_i,
  output logic                              cfg_wready_o,
  output logic [1:0]                        cfg_bresp_o,
  output logic                              cfg_bvalid_o,
  input  wire logic                         cfg_bready_i,
  input  wire logic [awdf_pkg::CFG_AW-1:0]  cfg_araddr_i,
  input  wire logic                         cfg_arvalid_i,
  output logic                              cfg_arready_o,
  output logic [31:0]                       cfg_rdata_o,
  output logic [1:0]                        cfg_rresp_o,
  output logic                              cfg_rvalid_o,
  input  wire logic                         cfg_rready_i
);
  // payload is data plus strobes, protected as one secded word
  localparam int SW = DATA_W / 8;
  localparam int K  = DATA_W + SW;
  localparam int P  = awdf_pkg::par_bits(K);
  localparam int N  = K + P;
  localparam int AW = awdf_pkg::AW;
  localparam int CW = awdf_pkg::CNT_W;
  localparam int TW = awdf_pkg::TH_W;

  function automatic logic [N:0] ecc_enc(input logic [K-1:0] d);
    logic [N:0] c;
    int         i;
    int         j;
    int         p;
    c = '0;
    j = 0;
    for (i = 1; i <= N; i++) begin
      if ((i & (i - 1)) != 0) begin
        c[i] = d[j];
        j++;
      end
    end
    for (p = 0; p < P; p++) begin
      for (i = 1; i <= N; i++) begin
        if ((((i >> p) & 1) == 1) && (i != (1 << p))) begin
          c[1 << p] = c[1 << p] ^ c[i];
        end
      end
    end
    c[0] = ^c[N:1];
    return c;
  endfunction

  // returns {double, single, corrected payload}
  function automatic logic [K+1:0] ecc_dec(input logic [N:0] c);
    logic [N:0]   f;
    logic [K-1:0] d;
    logic         sgl;
    logic         dbl;
    int           s;
    int           i;
    int           j;
    f = c;
    d = '0;
    sgl = 1'b0;
    dbl = 1'b0;
    s = 0;
    for (i = 1; i <= N; i++) begin
      if (c[i]) begin
        s = s ^ i;
      end
    end
    if (^c) begin
      if (s <= N) begin
        sgl = 1'b1;
        if (s != 0) begin
          f[s] = ~f[s];
        end
      end else begin
        dbl = 1'b1;
      end
    end else if (s != 0) begin
      dbl = 1'b1;
    end
    j = 0;
    for (i = 1; i <= N; i++) begin
      if ((i & (i - 1)) != 0) begin
        d[j] = f[i];
        j++;
      end
    end
    return {dbl, sgl, d};
  endfunction

  // configuration registers
  logic [awdf_pkg::CTRL_W-1:0] ctrl;
  logic [TW-1:0]               full_th;
  logic [TW-1:0]               empty_th;

  wire ecc_en = ctrl[awdf_pkg::CTRL_ECC_EN_BIT];
  wire hold   = ctrl[awdf_pkg::CTRL_HOLD_BIT];
  // the hold bit doubles as the buffer's own reset and flushes it
  wire fifo_rst = rst_i | hold;

  // storage
  logic [N:0]    mem [awdf_pkg::DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] mem_cnt;

  wire wr_take = s_axi_wvalid_i & s_axi_wready_o;
  wire out_pop = m_axi_wvalid_o & m_axi_wready_i;
  wire load    = (mem_cnt != '0) & (~m_axi_wvalid_o | m_axi_wready_i);

  wire inj_d = ecc_en & ctrl[awdf_pkg::CTRL_INJ_D_BIT];
  wire inj_s = ecc_en & ctrl[awdf_pkg::CTRL_INJ_S_BIT] & ~inj_d;
  wire [N:0] inj_mask = ({{N{1'b0}}, inj_d | inj_s}
                         << awdf_pkg::INJ_POS_A)
                      | ({{N{1'b0}}, inj_d} << awdf_pkg::INJ_POS_B);
  wire [N:0] wr_code  = ecc_enc({s_axi_wstrb_i, s_axi_wdata_i}) ^ inj_mask;
  wire [K+1:0] dec    = ecc_dec(mem[rptr]);

  wire [CW-1:0] next_mem_cnt = mem_cnt + CW'(wr_take) - CW'(load);
  wire          next_ovalid  = load | (m_axi_wvalid_o & ~m_axi_wready_i);
  wire [CW-1:0] next_total   = next_mem_cnt + CW'(next_ovalid);

  always_ff @(posedge sys_clk_i) begin
    if (wr_take) begin
      mem[wptr] <= wr_code;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (fifo_rst) begin
      wptr    <= '0;
      rptr    <= '0;
      mem_cnt <= '0;
    end else begin
      wptr    <= wptr + AW'(wr_take);
      rptr    <= rptr + AW'(load);
      mem_cnt <= next_mem_cnt;
    end
  end

  // output stage: word and its error flags stand until taken
  always_ff @(posedge sys_clk_i) begin
    if (fifo_rst) begin
      m_axi_wvalid_o <= 1'b0;
      m_axi_wdata_o  <= '0;
      m_axi_wstrb_o  <= '0;
      sbiterr_o      <= 1'b0;
      dbiterr_o      <= 1'b0;
    end else if (load) begin
      m_axi_wvalid_o <= 1'b1;
      m_axi_wdata_o  <= dec[DATA_W-1:0];
      m_axi_wstrb_o  <= dec[K-1:DATA_W];
      sbiterr_o      <= ecc_en & dec[K];
      dbiterr_o      <= ecc_en & dec[K+1];
    end else if (out_pop) begin
      m_axi_wvalid_o <= 1'b0;
      sbiterr_o      <= 1'b0;
      dbiterr_o      <= 1'b0;
    end
  end

  // counts and flags; one clock so write and read counts are the same
  always_ff @(posedge sys_clk_i) begin
    if (fifo_rst) begin
      s_axi_wready_o  <= 1'b0;
      data_count_o    <= '0;
      wr_data_count_o <= '0;
      rd_data_count_o <= '0;
      prog_full_o     <= 1'b0;
      prog_empty_o    <= 1'b1;
      overflow_o      <= 1'b0;
      underflow_o     <= 1'b0;
    end else begin
      // ready is withdrawn as the count reaches full, so no write is ever rejected
      s_axi_wready_o  <= next_total < awdf_pkg::DEPTH_CNT;
      data_count_o    <= next_total;
      wr_data_count_o <= next_total;
      rd_data_count_o <= next_total;
      prog_full_o     <= next_total >= {2'h0, full_th};
      prog_empty_o    <= next_total <= {2'h0, empty_th};
      overflow_o      <= 1'b0;
      underflow_o     <= 1'b0;
    end
  end

  // axi4-lite slave
  logic [awdf_pkg::CFG_AW-1:0] aw_addr;
  logic [31:0]                 w_data;
  logic [3:0]                  w_strb;

  wire aw_hs    = cfg_awvalid_i & cfg_awready_o;
  wire w_hs     = cfg_wvalid_i & cfg_wready_o;
  wire b_hs     = cfg_bvalid_o & cfg_bready_i;
  wire ar_hs    = cfg_arvalid_i & cfg_arready_o;
  wire r_hs     = cfg_rvalid_o & cfg_rready_i;
  wire do_write = ~cfg_awready_o & ~cfg_wready_o & ~cfg_bvalid_o;

  wire sel_ctrl  = aw_addr == awdf_pkg::CTRL_OFS;
  wire sel_fth   = aw_addr == awdf_pkg::FULL_TH_OFS;
  wire sel_eth   = aw_addr == awdf_pkg::EMPTY_TH_OFS;
  wire sel_ro    = (aw_addr == awdf_pkg::STATUS_OFS)
                 | (aw_addr == awdf_pkg::COUNT_OFS);
  wire wr_mapped = sel_ctrl | sel_fth | sel_eth | sel_ro;
  wire [7:0] wbyte = w_strb[0] ? w_data[7:0] : 8'h00;

  wire [31:0] status = {24'h0,
                        data_count_o == '0,
                        ~s_axi_wready_o & ~fifo_rst,
                        prog_empty_o,
                        prog_full_o,
                        underflow_o,
                        overflow_o,
                        dbiterr_o,
                        sbiterr_o};

  logic [31:0] rd_mux;
  logic        rd_hit;
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (cfg_araddr_i)
      awdf_pkg::CTRL_OFS:     rd_mux = {28'h0, ctrl};
      awdf_pkg::FULL_TH_OFS:  rd_mux = {28'h0, full_th};
      awdf_pkg::EMPTY_TH_OFS: rd_mux = {28'h0, empty_th};
      awdf_pkg::STATUS_OFS:   rd_mux = status;
      awdf_pkg::COUNT_OFS:    rd_mux = {26'h0, data_count_o};
      default:                rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_awready_o <= 1'b1;
      cfg_wready_o  <= 1'b1;
      cfg_bvalid_o  <= 1'b0;
      cfg_bresp_o   <= awdf_pkg::RESP_OKAY;
      aw_addr       <= '0;
      w_data        <= 32'h0;
      w_strb        <= 4'h0;
    end else begin
      if (aw_hs) begin
        cfg_awready_o <= 1'b0;
        aw_addr       <= cfg_awaddr_i;
      end else if (b_hs) begin
        cfg_awready_o <= 1'b1;
      end
      if (w_hs) begin
        cfg_wready_o <= 1'b0;
        w_data       <= cfg_wdata_i;
        w_strb       <= cfg_wstrb_i;
      end else if (b_hs) begin
        cfg_wready_o <= 1'b1;
      end
      if (do_write) begin
        cfg_bvalid_o <= 1'b1;
        cfg_bresp_o  <= wr_mapped ? awdf_pkg::RESP_OKAY
                                  : awdf_pkg::RESP_SLVERR;
      end else if (b_hs) begin
        cfg_bvalid_o <= 1'b0;
      end
    end
  end

  // thresholds only move while the buffer is held in reset
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ctrl     <= awdf_pkg::CTRL_RST;
      full_th  <= awdf_pkg::FULL_TH_RST;
      empty_th <= awdf_pkg::EMPTY_TH_RST;
    end else if (do_write & w_strb[0]) begin
      if (sel_ctrl) begin
        ctrl <= wbyte[awdf_pkg::CTRL_W-1:0];
      end
      if (sel_fth & hold) begin
        full_th <= wbyte[TW-1:0];
      end
      if (sel_eth & hold) begin
        empty_th <= wbyte[TW-1:0];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_arready_o <= 1'b1;
      cfg_rvalid_o  <= 1'b0;
      cfg_rdata_o   <= 32'h0;
      cfg_rresp_o   <= awdf_pkg::RESP_OKAY;
    end else if (ar_hs) begin
      cfg_arready_o <= 1'b0;
      cfg_rvalid_o  <= 1'b1;
      cfg_rdata_o   <= rd_mux;
      cfg_rresp_o   <= rd_hit ? awdf_pkg::RESP_OKAY
                              : awdf_pkg::RESP_SLVERR;
    end else if (r_hs) begin
      cfg_arready_o <= 1'b1;
      cfg_rvalid_o  <= 1'b0;
    end
  end
endmodule

// *** dv/awdf_chk.sv ***
`timescale 1ns/1ps
module awdf_chk #(
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic                    sys_clk_i,
  input wire logic                    rst_i,
  // data channels
  input wire logic                    s_axi_wvalid_i,
  input wire logic                    s_axi_wready_o,
  input wire logic [DATA_W-1:0]       m_axi_wdata_o,
  input wire logic [DATA_W/8-1:0]     m_axi_wstrb_o,
  input wire logic                    m_axi_wvalid_o,
  input wire logic                    m_axi_wready_i,
  // sideband
  input wire logic                    sbiterr_o,
  input wire logic                    dbiterr_o,
  input wire logic                    overflow_o,
  input wire logic                    underflow_o,
  input wire logic                    prog_full_o,
  input wire logic                    prog_empty_o,
  input wire logic [awdf_pkg::CNT_W-1:0] wr_data_count_o,
  input wire logic [awdf_pkg::CNT_W-1:0] rd_data_count_o,
  input wire logic [awdf_pkg::CNT_W-1:0] data_count_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  wire push = s_axi_wvalid_i && s_axi_wready_o;
  wire pop  = m_axi_wvalid_o && m_axi_wready_i;

  property p_ovf; overflow_o == 1'b0; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow raised");
  property p_unf; underflow_o == 1'b0; endproperty
  a_unf: assert property (p_unf) else $error("underflow raised");
  property p_stall;
    m_axi_wvalid_o && !m_axi_wready_i |=> m_axi_wvalid_o
      && $stable(m_axi_wdata_o) && $stable(m_axi_wstrb_o);
  endproperty
  a_stall: assert property (p_stall) else $error("word moved");
  property p_up;
    push && !pop |=> data_count_o == $past(data_count_o) + 6'h1;
  endproperty
  a_up: assert property (p_up) else $error("count up wrong");
  property p_dn;
    pop && !push |=> data_count_o == $past(data_count_o) - 6'h1;
  endproperty
  a_dn: assert property (p_dn) else $error("count down wrong");
  property p_same;
    wr_data_count_o == data_count_o && rd_data_count_o == data_count_o;
  endproperty
  a_same: assert property (p_same) else $error("counts differ");
  property p_valid; m_axi_wvalid_o |-> data_count_o != 6'h0; endproperty
  a_valid: assert property (p_valid) else $error("valid empty");
  property p_full;
    data_count_o == awdf_pkg::DEPTH_CNT |-> prog_full_o && !s_axi_wready_o;
  endproperty
  a_full: assert property (p_full) else $error("full flags");
  property p_empty; data_count_o == 6'h0 |-> prog_empty_o; endproperty
  a_empty: assert property (p_empty) else $error("empty flag");
  property p_err; sbiterr_o || dbiterr_o |-> m_axi_wvalid_o; endproperty
  a_err: assert property (p_err) else $error("error flag idle");
  property p_pf_keep;
    push && !pop && prog_full_o |=> prog_full_o;
  endproperty
  a_pf_keep: assert property (p_pf_keep) else $error("pfull fell");
  property p_pe_keep;
    pop && !push && prog_empty_o |=> prog_empty_o;
  endproperty
  a_pe_keep: assert property (p_pe_keep) else $error("pempty fell");
  property p_cnt_max; data_count_o <= awdf_pkg::DEPTH_CNT; endproperty
  a_cnt_max: assert property (p_cnt_max) else $error("count high");
  c_full: cover property (data_count_o == awdf_pkg::DEPTH_CNT);
  c_stall: cover property (m_axi_wvalid_o && !m_axi_wready_i);
  c_dbit: cover property (dbiterr_o && pop);
endmodule

bind awdf_top awdf_chk #(.DATA_W(DATA_W)) i_awdf_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_wvalid_i(s_axi_wvalid_i),
  .s_axi_wready_o(s_axi_wready_o), .m_axi_wdata_o(m_axi_wdata_o),
  .m_axi_wstrb_o(m_axi_wstrb_o), .m_axi_wvalid_o(m_axi_wvalid_o),
  .m_axi_wready_i(m_axi_wready_i), .sbiterr_o(sbiterr_o),
  .dbiterr_o(dbiterr_o), .overflow_o(overflow_o),
  .underflow_o(underflow_o), .prog_full_o(prog_full_o),
  .prog_empty_o(prog_empty_o), .wr_data_count_o(wr_data_count_o),
  .rd_data_count_o(rd_data_count_o), .data_count_o(data_count_o));

// *** dv/awdf_sink.sv ***
`timescale 1ns/1ps
// downstream slave; records each word it takes with the error flags
module awdf_sink (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // write data channel
  input  wire logic [31:0] wdata_i,
  input  wire logic [3:0]  wstrb_i,
  input  wire logic [1:0]  err_i,
  input  wire logic        wvalid_i,
  output logic             wready_o,
  // capture side
  input  wire logic        stall_i,
  output logic             got_o,
  output logic [37:0]      word_o
);
  assign wready_o = !stall_i;
  always_ff @(posedge sys_clk_i) begin
    got_o  <= !rst_i && wvalid_i && wready_o;
    word_o <= {err_i, wstrb_i, wdata_i};
  end
endmodule

// *** dv/awdf_top_bench.sv ***
`timescale 1ns/1ps
module awdf_top_bench;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [31:0] wd = 32'h0, cwd = 32'h0, rd, md, val;
  logic [3:0]  ws = 4'h0, ms;
  logic        wv = 1'b0, wr, mv, mr, stall = 1'b1, got, sb, db;
  logic        ovf, unf, pf, pe, awr, cwr_o, bv, arr, rv;
  logic        awv = 1'b0, cwv = 1'b0, brd = 1'b0, arv = 1'b0, rrd = 1'b0;
  logic [5:0]  wc, rc, dc;
  logic [7:0]  awa = 8'h0, ara = 8'h0;
  logic [1:0]  bresp, rresp, resp;
  logic [37:0] word;
  int          err_count = 0, tests_run = 0, cyc = 0;

  initial forever #12.5 sys_clk_i = ~sys_clk_i;

  awdf_top i_awdf_top (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .s_axi_wdata_i(wd),
    .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
    .m_axi_wdata_o(md), .m_axi_wstrb_o(ms), .m_axi_wvalid_o(mv),
    .m_axi_wready_i(mr), .sbiterr_o(sb), .dbiterr_o(db),
    .overflow_o(ovf), .underflow_o(unf), .prog_full_o(pf),
    .prog_empty_o(pe), .wr_data_count_o(wc), .rd_data_count_o(rc),
    .data_count_o(dc), .cfg_awaddr_i(awa), .cfg_awvalid_i(awv),
    .cfg_awready_o(awr), .cfg_wdata_i(cwd), .cfg_wstrb_i(4'hf),
    .cfg_wvalid_i(cwv), .cfg_wready_o(cwr_o), .cfg_bresp_o(bresp),
    .cfg_bvalid_o(bv), .cfg_bready_i(brd), .cfg_araddr_i(ara),
    .cfg_arvalid_i(arv), .cfg_arready_o(arr), .cfg_rdata_o(rd),
    .cfg_rresp_o(rresp), .cfg_rvalid_o(rv), .cfg_rready_i(rrd));

  awdf_sink i_awdf_sink (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .wdata_i(md), .wstrb_i(ms),
    .err_i({db, sb}), .wvalid_i(mv), .wready_o(mr), .stall_i(stall),
    .got_o(got), .word_o(word));

  function automatic logic [31:0] pat(input int i);
    return 32'h3c0000a5 ^ (32'(i) << 8);
  endfunction
  function automatic logic [3:0] stb(input int i);
    return 4'(i) ^ 4'h5;
  endfunction

  task automatic chk(input string n, input logic [37:0] e,
                     input logic [37:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cfg_wr(input logic [7:0] a, input logic [31:0] d);
    awa <= a;
    cwd <= d;
    awv <= 1'b1;
    cwv <= 1'b1;
    brd <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (awr) awv <= 1'b0;
      if (cwr_o) cwv <= 1'b0;
    end while (bv !== 1'b1);
    resp = bresp;
    brd <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  task automatic cfg_rd(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rrd <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    val = rd;
    resp = rresp;
    rrd <= 1'b0;
    @(posedge sys_clk_i);
  endtask

  // valid stays up between words so the payload changes only after a take
  task automatic push_n(input int first, input int n);
    for (int i = first; i < first + n; i++) begin
      wd <= pat(i);
      ws <= stb(i);
      wv <= 1'b1;
      do @(posedge sys_clk_i); while (wr !== 1'b1);
    end
    wv <= 1'b0;
  endtask

  task automatic pop(input int i, input logic [1:0] e, input logic [37:0] m);
    int k;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      #1;
      k++;
    end while (got !== 1'b1 && k < 50);
    chk("out word", {e, stb(i), pat(i)} & m, word & m);
  endtask

  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_count++;
      print_verdict;
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    settle;
    chk("count", 38'h0, dc);
    chk("prog_empty", 38'h1, pe);
    chk("prog_full", 38'h0, pf);
    cfg_rd(awdf_pkg::CTRL_OFS);
    chk("ctrl", awdf_pkg::CTRL_RST, val);
    cfg_rd(awdf_pkg::FULL_TH_OFS);
    chk("full th", awdf_pkg::FULL_TH_RST, val);
    cfg_rd(awdf_pkg::EMPTY_TH_OFS);
    chk("empty th", awdf_pkg::EMPTY_TH_RST, val);
    cfg_rd(8'h14);
    chk("unmapped resp", awdf_pkg::RESP_SLVERR, resp);
    chk("unmapped data", 38'h0, val);
    cfg_wr(8'h14, 32'h0);
    chk("unmapped wr resp", awdf_pkg::RESP_SLVERR, resp);
    cfg_rd(awdf_pkg::STATUS_OFS);
    chk("status idle", 38'ha0, val);
    // fill until refused while the far side stalls
    push_n(0, 16);
    settle;
    chk("wready", 38'h0, wr);
    chk("count", awdf_pkg::DEPTH_CNT, dc);
    chk("wr count", awdf_pkg::DEPTH_CNT, wc);
    chk("rd count", awdf_pkg::DEPTH_CNT, rc);
    chk("prog_full", 38'h1, pf);
    chk("overflow", 38'h0, ovf);
    cfg_rd(awdf_pkg::STATUS_OFS);
    chk("status full", 38'h50, val);
    stall <= 1'b0;
    for (int i = 0; i < 16; i++) pop(i, 2'b00, '1);
    stall <= 1'b1;
    settle;
    chk("count", 38'h0, dc);
    chk("underflow", 38'h0, unf);
    // thresholds move only while the buffer is held
    cfg_wr(awdf_pkg::FULL_TH_OFS, 32'h4);
    chk("wr resp", awdf_pkg::RESP_OKAY, resp);
    cfg_rd(awdf_pkg::FULL_TH_OFS);
    chk("full th kept", awdf_pkg::FULL_TH_RST, val);
    chk("rd resp", awdf_pkg::RESP_OKAY, resp);
    cfg_wr(awdf_pkg::CTRL_OFS, 32'h9);
    cfg_wr(awdf_pkg::FULL_TH_OFS, 32'h4);
    cfg_wr(awdf_pkg::EMPTY_TH_OFS, 32'h1);
    cfg_wr(awdf_pkg::CTRL_OFS, 32'h1);
    cfg_rd(awdf_pkg::EMPTY_TH_OFS);
    chk("empty th", 38'h1, val);
    for (int n = 1; n <= 5; n++) begin
      push_n(16 + n, 1);
      settle;
      chk("prog_full", 38'(n >= 4), pf);
      chk("prog_empty", 38'(n <= 1), pe);
    end
    stall <= 1'b0;
    for (int n = 1; n <= 5; n++) pop(16 + n, 2'b00, '1);
    stall <= 1'b1;
    // ecc: single, double, then clean word
    cfg_wr(awdf_pkg::CTRL_OFS, 32'h3);
    push_n(30, 1);
    cfg_wr(awdf_pkg::CTRL_OFS, 32'h5);
    push_n(31, 1);
    cfg_wr(awdf_pkg::CTRL_OFS, 32'h1);
    push_n(32, 1);
    // injection is ignored while ecc is off
    cfg_wr(awdf_pkg::CTRL_OFS, 32'h6);
    push_n(33, 1);
    cfg_wr(awdf_pkg::CTRL_OFS, 32'h1);
    settle;
    stall <= 1'b0;
    pop(30, 2'b01, '1);
    pop(31, 2'b10, {2'b11, 36'h0});
    pop(32, 2'b00, '1);
    pop(33, 2'b00, '1);
    print_verdict;
  end
endmodule
